// >>> bench/gpio_top_props.sv
// Purpose: port-level checks for the gpio block
// Assumes: function registers only change by bus writes
// Notes: routing checks wait for inputs to settle 4 cycles
`timescale 1ns/10ps
`default_nettype none
module gpio_top_props (
  input wire logic clk,
  input wire logic srst,
  input wire gpio_pkg::reg_req_type req,
  input wire logic [31:0] rdata,
  input wire logic [8:0] pin_i,
  input wire logic [8:0] pin_o,
  input wire logic [8:0] pin_oe,
  input wire logic power_down,
  input wire gpio_pkg::periph_out_type periph_o,
  input wire gpio_pkg::periph_in_type periph_i,
  input wire logic lin_rx_pin,
  input wire logic lin_tx_pin,
  input wire logic sti_pin,
  input wire logic external_interrupt_0,
  input wire logic external_interrupt_4
);
  import gpio_pkg::*;
  logic [7:0] p0f_q;
  logic [31:0] p2f_q;
  logic run;
  assign run = !power_down;
  // shadow copies of the port0 and port2 function registers seen on the bus
  always_ff @(posedge clk)
    if (srst)
    begin
      p0f_q <= 8'h00;
      p2f_q <= P2_FUNC_RESET;
    end
    else if (req.wr && req.addr == P0_FUNC_ADDR)
      p0f_q <= req.wdata[7:0];
    else if (req.wr && req.addr == P2_FUNC_ADDR)
      p2f_q <= req.wdata & FUNC_MASK_P2;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // synchroniser lag is up to two cycles, so four is enough
  sequence steady(c, s);
    (c && $stable(s))[*4];
  endsequence
  a_read_idle_zero: assert property (
    !$past(req.rd) |-> rdata == 32'h0) else $error("rdata not idle");
  a_reset_pins_in: assert property (
    $fell(srst) |-> pin_oe == 9'h000) else $error("pin driven at reset");
  a_dat_to_pins: assert property (
    req.wr && req.addr == P0_DAT_ADDR && p0f_q == 8'h00 && run ##1 run
    |=> pin_oe[4:0] == $past(req.wdata[28:24], 2)
    && (pin_o[4:0] & pin_oe[4:0])
    == ($past(req.wdata[20:16], 2) & $past(req.wdata[28:24], 2)))
    else $error("port0 pins wrong");
  a_pd_freeze: assert property (
    power_down && $past(power_down) |-> $stable(pin_o) && $stable(pin_oe))
    else $error("pins moved in power-down");
  a_external_interrupt_0_level: assert property (
    steady(p0f_q[1:0] == 2'h1, pin_i[0])
    |-> external_interrupt_0 == pin_i[0]) else $error("external_interrupt_0 wrong");
  a_external_interrupt_4_level: assert property (
    steady(!p2f_q[0], pin_i[7])
    |-> external_interrupt_4 == pin_i[7]) else $error("external_interrupt_4 wrong");
  a_sti_route: assert property (
    steady(p2f_q[24] && run, periph_o.sti_data)
    |-> sti_pin == periph_o.sti_data) else $error("sti not routed");
  a_sti_block: assert property (
    (!p2f_q[24])[*4] |-> $stable(sti_pin)) else $error("sti leaks");
  a_uart_tx_route: assert property (
    steady(p2f_q[20] && !p2f_q[0] && run, periph_o.uart_txd)
    |-> lin_tx_pin == periph_o.uart_txd) else $error("txd not routed");
  a_rx_path_on: assert property (
    steady(p2f_q[16], lin_rx_pin)
    |-> periph_i.lin_rxd_uart == lin_rx_pin) else $error("rx path wrong");
  a_rx_path_off: assert property (
    (!p2f_q[16])[*4] |-> periph_i.lin_rxd_uart) else $error("rx not off");
  a_pin8_route: assert property (
    steady(p2f_q[4] && run, periph_o.lin_rx_data)
    |-> pin_oe[8] && pin_o[8] == periph_o.lin_rx_data)
    else $error("pin8 not routed");
endmodule
bind gpio_top gpio_top_props u_props (
  .clk(clk), .srst(srst), .req(req), .rdata(rdata), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe(pin_oe), .power_down(power_down),
  .periph_o(periph_o), .periph_i(periph_i), .lin_rx_pin(lin_rx_pin),
  .lin_tx_pin(lin_tx_pin), .sti_pin(sti_pin),
  .external_interrupt_0(external_interrupt_0),
  .external_interrupt_4(external_interrupt_4)
);
`default_nettype wire

// >>> bench/pin_partner.sv
// Purpose: far side of the pins and on-chip peripherals
// Assumes: every pin has a pull-up
// Notes: peripheral data toggles every 8 cycles
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input wire logic clk,
  input wire logic srst,
  input wire logic [8:0] pin_o,
  input wire logic [8:0] pin_oe,
  input wire logic [8:0] ext_en,
  input wire logic [8:0] ext_val,
  output logic [8:0] pin_i,
  output gpio_pkg::periph_out_type periph_o,
  output logic lin_rx_pin
);
  import gpio_pkg::*;
  logic [7:0] cnt_q;
  always_ff @(posedge clk)
    if (srst)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  // source holds level
  // an outside source keeps its level until the bench lets go
  assign pin_i = (pin_oe & pin_o)
    | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
  assign periph_o = {11{cnt_q[3]}} ^ 11'h2A5;
  assign lin_rx_pin = cnt_q[4];
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Purpose: register-level tests of the gpio block
// Assumes: one idle cycle after each bus access
// Notes: port2 routing is judged by the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpio_pkg::*;
  logic clk, srst, power_down, lin_rx_pin, lin_tx_pin, sti_pin;
  reg_req_type req;
  logic [31:0] rdata;
  logic [8:0] pin_i, pin_o, pin_oe, ext_en, ext_val;
  logic [3:0] irq;
  periph_out_type periph_o;
  periph_in_type periph_i;
  int num_errors = 0;
  int cmp_count = 0;
  logic [31:0] p2_cfg [4] = '{32'h01110011, 32'h00000000,
    32'h00100010, 32'h01010001};
  gpio_top dut (
    .clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .power_down(power_down), .periph_o(periph_o),
    .periph_i(periph_i), .hv_link_o(), .hv_link_i(2'h0),
    .lin_tx_pin(lin_tx_pin), .lin_rx_pin(lin_rx_pin),
    .sti_pin(sti_pin), .external_interrupt_0(irq[0]),
    .external_interrupt_1(irq[1]), .external_interrupt_4(irq[2]),
    .external_interrupt_5(irq[3])
  );
  pin_partner far (
    .clk(clk), .srst(srst), .pin_o(pin_o), .pin_oe(pin_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i),
    .periph_o(periph_o), .lin_rx_pin(lin_rx_pin)
  );
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // the idle cycle keeps two requests from landing in one time step
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    req <= '{a, d, 1'h1, 1'h0};
    idle(1);
    req <= '0;
    idle(1);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    req <= '{a, 32'h0, 1'h0, 1'h1};
    idle(1);
    req <= '0;
    @(negedge clk);
    chk(rdata, e);
    idle(1);
  endtask
  initial
  begin
    idle(20000);
    num_errors++;
    summarize();
  end
  initial
  begin
    srst = 1'h1;
    req = '0;
    power_down = 1'h0;
    ext_en = 9'h000;
    ext_val = 9'h000;
    idle(16);
    srst <= 1'h0;
    idle(4);
    chk({23'h0, pin_oe}, 32'h0);
    rc(P2_FUNC_ADDR, P2_FUNC_RESET);
    rc(P0_FUNC_ADDR, 32'h0);
    rc(P0_DAT_ADDR, 32'h0000001F);
    $display("reset test done");
    wr(P0_DAT_ADDR, 32'h1F150000);
    idle(4);
    rc(P0_DAT_ADDR, 32'h1F150015);
    wr(P0_SET_ADDR, 32'h000A0000);
    wr(P0_CLR_ADDR, 32'h00150000);
    idle(4);
    rc(P0_DAT_ADDR, 32'h1F0A000A);
    rc(P0_SET_ADDR, 32'h0);
    rc(32'hFFFF0D50, 32'h0);
    $display("output test done");
    power_down <= 1'h1;
    wr(P0_DAT_ADDR, 32'h1F1F0000);
    idle(3);
    chk({27'h0, pin_o[4:0]}, 32'h0A);
    power_down <= 1'h0;
    idle(3);
    chk({27'h0, pin_o[4:0]}, 32'h1F);
    $display("power-down test done");
    wr(P0_DAT_ADDR, 32'h0);
    wr(P0_FUNC_ADDR, 32'h1);
    ext_en <= 9'h1FF;
    ext_val <= 9'h012;
    idle(5);
    rc(P0_DAT_ADDR, 32'h00000012);
    ext_val <= 9'h193;
    idle(5);
    chk({29'h0, irq[3:2], irq[0]}, 32'h7);
    ext_val <= 9'h000;
    idle(5);
    chk({29'h0, irq[3:2], irq[0]}, 32'h0);
    ext_en <= 9'h000;
    $display("input test done");
    // reserved bits stay zero; bit 16 is set only in the first and fourth configurations
    for (int i = 0; i < 4; i++)
    begin
      wr(P2_FUNC_ADDR, p2_cfg[i]);
      rc(P2_FUNC_ADDR, p2_cfg[i]);
      idle(40);
    end
    // pin 7 pass-through would otherwise own the transmit path
    wr(P2_FUNC_ADDR, 32'h0);
    wr(P2_DAT_ADDR, 32'h20200000);
    idle(4);
    chk({31'h0, lin_tx_pin}, 32'h1);
    wr(P2_CLR_ADDR, 32'h00200000);
    idle(4);
    chk({31'h0, lin_tx_pin}, 32'h0);
    $display("routing test done");
    summarize();
  end
endmodule
`default_nettype wire

// >>> src/gpio_pkg.sv
// Purpose: shared constants and types for the three-port gpio block
// Assumes: 32-bit register port, byte addresses
// Notes:
// What this block does
// - nine pins in ports of 5, 2, 2
// - reset leaves every pin plain gpio
// - interrupt pins 0,5,7,8 level high, unlatched
// - pins hold their level in power-down, except pin 4 while it carries the clock output
// - port0 bits 24-28 select direction
// - port0 bits 16-20 drive output values
// - port0 bits 0-4 read pin levels
// - port2 bit 24 routes serial test output
// - port2 bit 20 picks uart or pin 12
// - port2 bit 16 enables lin receive path
// - port2 bit 4 drives lin receive on pin 8
// - port2 bit 0 passes pin 7 to lin
// - port0 alternate spi, interrupt, clock output
// - port1/2 alternate uart and interrupts
// - four registers per port
// - port0 bits 5,6 internal high-voltage link
// - set register drives ones high
package gpio_pkg;
  localparam logic [31:0] P0_FUNC_ADDR = 32'hFFFF0D00;
  localparam logic [31:0] P0_DAT_ADDR = 32'hFFFF0D20;
  localparam logic [31:0] P0_SET_ADDR = 32'hFFFF0D24;
  localparam logic [31:0] P0_CLR_ADDR = 32'hFFFF0D28;
  localparam logic [31:0] P1_FUNC_ADDR = 32'hFFFF0D04;
  localparam logic [31:0] P1_DAT_ADDR = 32'hFFFF0D30;
  localparam logic [31:0] P1_SET_ADDR = 32'hFFFF0D34;
  localparam logic [31:0] P1_CLR_ADDR = 32'hFFFF0D38;
  localparam logic [31:0] P2_FUNC_ADDR = 32'hFFFF0D08;
  localparam logic [31:0] P2_DAT_ADDR = 32'hFFFF0D40;
  localparam logic [31:0] P2_SET_ADDR = 32'hFFFF0D44;
  localparam logic [31:0] P2_CLR_ADDR = 32'hFFFF0D48;
  localparam int DIR_LSB = 24;
  localparam int OUT_LSB = 16;
  localparam int IN_LSB = 0;
  localparam int P2_STI_BIT = 24;
  localparam int P2_TXSEL_BIT = 20;
  localparam int P2_RXEN_BIT = 16;
  localparam int P2_PIN8_BIT = 4;
  localparam int P2_PIN7_BIT = 0;
  localparam logic [31:0] P2_FUNC_RESET = 32'h01000000;
  localparam logic [31:0] FUNC_RESET = 32'h00000000;
  localparam logic [31:0] FUNC_MASK_P0 = 32'h000000FF;
  localparam logic [31:0] FUNC_MASK_P1 = 32'h0000000F;
  localparam logic [31:0] FUNC_MASK_P2 = 32'h01110011;
  localparam int P0_WIDTH = 7;
  localparam int P1_WIDTH = 2;
  localparam int P2_WIDTH = 7;
  localparam int NUM_PORTS = 3;
  localparam real DIVIDED_CLOCK_OUTPUT_MHZ = 2.56;
  localparam real CLK_MHZ = 200.0;
  localparam int DIVIDED_CLOCK_OUTPUT_HALF_CYCLES = int'(CLK_MHZ / (2.0 * DIVIDED_CLOCK_OUTPUT_MHZ));
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  typedef struct packed {
    logic spi_ss_o;
    logic spi_ss_oe;
    logic spi_sclk_o;
    logic spi_sclk_oe;
    logic spi_miso_o;
    logic spi_miso_oe;
    logic spi_mosi_o;
    logic spi_mosi_oe;
    logic uart_txd;
    logic lin_rx_data;
    logic sti_data;
  } periph_out_type;
  typedef struct packed {
    logic spi_ss_i;
    logic spi_sclk_i;
    logic spi_miso_i;
    logic spi_mosi_i;
    logic uart_rxd;
    logic lin_tx_data;
    logic lin_rxd_uart;
  } periph_in_type;
endpackage

// >>> src/gpio_port.sv
// Purpose: one port's direction/data, set and clear registers
// Assumes: direction 24+, output 16+, input 0+ within the data word
// Notes: function register is kept by the top
`timescale 1ns/10ps
`default_nettype none
module gpio_port
  import gpio_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic dat_wr,
  input wire logic set_wr,
  input wire logic clr_wr,
  input wire logic [31:0] wdata,
  input wire logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] dir_q,
  output logic [WIDTH-1:0] out_q,
  output logic [31:0] dat_word
);
  always_ff @(posedge clk)
  begin
    if (srst)
      dir_q <= '0;
    else if (dat_wr)
      dir_q <= wdata[DIR_LSB +: WIDTH];
  end
  // output register; set and clear act per bit
  always_ff @(posedge clk)
  begin
    if (srst)
      out_q <= '0;
    else if (dat_wr)
      out_q <= wdata[OUT_LSB +: WIDTH];
    else if (set_wr)
      out_q <= out_q | wdata[OUT_LSB +: WIDTH];
    else if (clr_wr)
      out_q <= out_q & ~wdata[OUT_LSB +: WIDTH];
  end
  // input bits read only, writes ignored
  always_comb
  begin
    dat_word = '0;
    dat_word[DIR_LSB +: WIDTH] = dir_q;
    dat_word[OUT_LSB +: WIDTH] = out_q;
    dat_word[IN_LSB +: WIDTH] = pin_level;
  end
endmodule
`default_nettype wire

// >>> src/gpio_sync.sv
// Purpose: two-flop synchroniser vector
// Assumes: single clk domain downstream
// Notes: first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module gpio_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> src/gpio_top.sv
// Purpose: nine-pin gpio block with function routing
// Assumes: one 200 MHz clock, synchronous reset, plain register port
// Notes: pins are split into input, output and output enable
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module gpio_top (
  input wire logic clk,
  input wire logic srst,
  input wire gpio_pkg::reg_req_type req,
  output logic [31:0] rdata,
  input wire logic [8:0] pin_i,
  output logic [8:0] pin_o,
  output logic [8:0] pin_oe,
  input wire logic power_down,
  input wire gpio_pkg::periph_out_type periph_o,
  output gpio_pkg::periph_in_type periph_i,
  output logic [1:0] hv_link_o,
  input wire logic [1:0] hv_link_i,
  output logic lin_tx_pin,
  input wire logic lin_rx_pin,
  output logic sti_pin,
  output logic external_interrupt_0,
  output logic external_interrupt_1,
  output logic external_interrupt_4,
  output logic external_interrupt_5
);
  import gpio_pkg::*;

  logic [8:0] pin_sync;
  logic [2:0] misc_sync;
  logic [31:0] func0_q, func1_q, func2_q;
  logic [P0_WIDTH-1:0] dir0, out0, lvl0;
  logic [P1_WIDTH-1:0] dir1, out1;
  logic [P2_WIDTH-1:0] dir2, out2, lvl2;
  logic [31:0] word0, word1, word2;
  logic [8:0] drv_o, drv_oe;
  logic [8:0] hold_o_q, hold_oe_q;
  logic [7:0] divided_clock_output_cnt_q;
  logic divided_clock_output_q;
  logic divided_clock_output_sel_q;
  logic lin_rx_s;

  // pin inputs and link levels pass two flip-flops
  gpio_sync #(.WIDTH(9)) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .async_in(pin_i),
    .sync_out(pin_sync)
  );
  gpio_sync #(.WIDTH(3)) u_misc_sync (
    .clk(clk),
    .srst(srst),
    .async_in({lin_rx_pin, hv_link_i}),
    .sync_out(misc_sync)
  );
  assign lin_rx_s = misc_sync[2];

  // port0 bits 5,6 carry the internal high-voltage link
  assign lvl0 = {misc_sync[1:0], pin_sync[4:0]};
  // internal pin 11 reads back the lin pin when path is off
  assign lvl2 = {1'b0, out2[5], lin_rx_s & ~func2_q[P2_RXEN_BIT],
    2'b00, pin_sync[8:7]};

  // port widths 5(+2 internal), 2, 2(+5 internal)
  gpio_port #(.WIDTH(P0_WIDTH)) u_port0 (
    .clk(clk),
    .srst(srst),
    .dat_wr(req.wr && req.addr == P0_DAT_ADDR),
    .set_wr(req.wr && req.addr == P0_SET_ADDR),
    .clr_wr(req.wr && req.addr == P0_CLR_ADDR),
    .wdata(req.wdata),
    .pin_level(lvl0),
    .dir_q(dir0),
    .out_q(out0),
    .dat_word(word0)
  );
  gpio_port #(.WIDTH(P1_WIDTH)) u_port1 (
    .clk(clk),
    .srst(srst),
    .dat_wr(req.wr && req.addr == P1_DAT_ADDR),
    .set_wr(req.wr && req.addr == P1_SET_ADDR),
    .clr_wr(req.wr && req.addr == P1_CLR_ADDR),
    .wdata(req.wdata),
    .pin_level(pin_sync[6:5]),
    .dir_q(dir1),
    .out_q(out1),
    .dat_word(word1)
  );
  gpio_port #(.WIDTH(P2_WIDTH)) u_port2 (
    .clk(clk),
    .srst(srst),
    .dat_wr(req.wr && req.addr == P2_DAT_ADDR),
    .set_wr(req.wr && req.addr == P2_SET_ADDR),
    .clr_wr(req.wr && req.addr == P2_CLR_ADDR),
    .wdata(req.wdata),
    .pin_level(lvl2),
    .dir_q(dir2),
    .out_q(out2),
    .dat_word(word2)
  );

  // function registers reset to plain gpio, except port2 which resets with bit 24 routing serial test output
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      func0_q <= FUNC_RESET;
      func1_q <= FUNC_RESET;
      func2_q <= P2_FUNC_RESET;
    end
    else if (req.wr)
    begin
      // reserved bits are masked so they always read zero
      if (req.addr == P0_FUNC_ADDR)
        func0_q <= req.wdata & FUNC_MASK_P0;
      if (req.addr == P1_FUNC_ADDR)
        func1_q <= req.wdata & FUNC_MASK_P1;
      if (req.addr == P2_FUNC_ADDR)
        func2_q <= req.wdata & FUNC_MASK_P2;
    end
  end

  // read data stands the cycle after the strobe; set/clear read zero
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= '0;
    else if (req.rd)
    begin
      unique case (req.addr)
        P0_FUNC_ADDR: rdata <= func0_q;
        P1_FUNC_ADDR: rdata <= func1_q;
        P2_FUNC_ADDR: rdata <= func2_q;
        P0_DAT_ADDR: rdata <= word0;
        P1_DAT_ADDR: rdata <= word1;
        P2_DAT_ADDR: rdata <= word2;
        default: rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  // divided clock output, half period in core cycles
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      divided_clock_output_cnt_q <= '0;
      divided_clock_output_q <= 1'b0;
    end
    else if (divided_clock_output_cnt_q == 8'(DIVIDED_CLOCK_OUTPUT_HALF_CYCLES - 1))
    begin
      divided_clock_output_cnt_q <= '0;
      divided_clock_output_q <= ~divided_clock_output_q;
    end
    else
      divided_clock_output_cnt_q <= divided_clock_output_cnt_q + 8'h01;
  end

  // pin function per pin; function fields two bits for port0/1
  always_comb
  begin
    drv_o = {out2[1:0], out1, out0[4:0]};
    drv_oe = {dir2[1:0], dir1, dir0[4:0]};
    // spi on pins 0-3, clock out on pin 4
    if (func0_q[1:0] == 2'h2)
    begin
      drv_o[0] = periph_o.spi_ss_o;
      drv_oe[0] = periph_o.spi_ss_oe;
    end
    if (func0_q[3:2] == 2'h1)
    begin
      drv_o[1] = periph_o.spi_sclk_o;
      drv_oe[1] = periph_o.spi_sclk_oe;
    end
    if (func0_q[5:4] == 2'h1)
    begin
      drv_o[2] = periph_o.spi_miso_o;
      drv_oe[2] = periph_o.spi_miso_oe;
    end
    if (func0_q[7:6] == 2'h1)
    begin
      drv_o[3] = periph_o.spi_mosi_o;
      drv_oe[3] = periph_o.spi_mosi_oe;
    end
    if (func1_q[1:0] == 2'h2)
      drv_oe[5] = 1'b0;
    if (func1_q[3:2] == 2'h1)
    begin
      drv_o[6] = periph_o.uart_txd;
      drv_oe[6] = 1'b1;
    end
    // pin 7 becomes an input feeding the transceiver
    if (func2_q[P2_PIN7_BIT])
      drv_oe[7] = 1'b0;
    // pin 8 carries the lin receive data out
    if (func2_q[P2_PIN8_BIT])
    begin
      drv_o[8] = periph_o.lin_rx_data;
      drv_oe[8] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hold_o_q <= '0;
      hold_oe_q <= '0;
    end
    else if (!power_down)
    begin
      hold_o_q <= drv_o;
      hold_oe_q <= drv_oe;
    end
  end
  // registered pins change on the edge after the write
  assign pin_o = {hold_o_q[8:5], divided_clock_output_sel_q ? divided_clock_output_q : hold_o_q[4],
    hold_o_q[3:0]};
  assign pin_oe = {hold_oe_q[8:5], divided_clock_output_sel_q | hold_oe_q[4],
    hold_oe_q[3:0]};

  always_ff @(posedge clk)
  begin
    if (srst)
      divided_clock_output_sel_q <= 1'b0;
    else if (!power_down)
      divided_clock_output_sel_q <= func0_q[7:6] == 2'h0 && func0_q[1:0] == 2'h3;
  end

  // transmit source is uart or internal pin 12
  // pin 7 overrides when passing through
  always_ff @(posedge clk)
  begin
    if (srst)
      lin_tx_pin <= 1'b1;
    else if (func2_q[P2_PIN7_BIT])
      lin_tx_pin <= pin_sync[7];
    else if (func2_q[P2_TXSEL_BIT])
      lin_tx_pin <= periph_o.uart_txd;
    else
      lin_tx_pin <= out2[5];
  end

  // serial test output selected by bit 24, internal pin 13 otherwise
  always_ff @(posedge clk)
  begin
    if (srst)
      sti_pin <= 1'b0;
    else
      sti_pin <= func2_q[P2_STI_BIT] ? periph_o.sti_data : out2[6];
  end

  // high-voltage link driven from port0 bits 5, 6
  assign hv_link_o = out0[6:5];

  // receive path gated by bit 16
  always_comb
  begin
    periph_i.spi_ss_i = pin_sync[0];
    periph_i.spi_sclk_i = pin_sync[1];
    periph_i.spi_miso_i = pin_sync[2];
    periph_i.spi_mosi_i = pin_sync[3];
    periph_i.uart_rxd = pin_sync[5];
    periph_i.lin_tx_data = lin_tx_pin;
    periph_i.lin_rxd_uart = func2_q[P2_RXEN_BIT] ? lin_rx_s : 1'b1;
  end

  // requests follow the synchronised level, unlatched
  assign external_interrupt_0 = pin_sync[0] && func0_q[1:0] == 2'h1;
  assign external_interrupt_1 = pin_sync[5] && func1_q[1:0] == 2'h1;
  assign external_interrupt_4 = pin_sync[7] && !func2_q[P2_PIN7_BIT];
  assign external_interrupt_5 = pin_sync[8] && !func2_q[P2_PIN8_BIT];
endmodule
`default_nettype wire
